/* File: otg_far_end.sv */
// Behavioural model of the remote OTG device at the far end of the port.
`timescale 1ns/10ps
module otg_far_end (
  input wire logic pullup_near,
  input wire logic reset_near,
  input wire logic vbus_near,
  input wire logic far_pullup,
  input wire logic far_vbus,
  output logic dp_line,
  output logic dm_line,
  output logic vbus_sess_vld,
  output logic vbus_sess_end
);
  // ==========================================================================
  // Bus power: a session lasts while either source holds the bus up.
  // The bench raises far_vbus only for a remote A-device or a short charge pulse.
  assign vbus_sess_vld = vbus_near | far_vbus;
  assign vbus_sess_end = ~vbus_sess_vld;
  // ==========================================================================
  // Lines: the host pull-downs win once both pull-ups are released, giving SE0.
  // Pulses and connects always use DP, so DM never leaves the low level.
  assign dp_line = (pullup_near | far_pullup) & ~reset_near;
  assign dm_line = 1'b0;
endmodule

/* File: otg_pkg.sv */
// Constants, carriers and state types of the OTG port role control block.
package otg_pkg;
  // ==========================================================================
  // Register byte addresses on the APB port.
  localparam logic [11:0] ADDR_IRQ_PERIPH = 12'h218;
  localparam logic [11:0] ADDR_CTRL = 12'h374;
  localparam logic [11:0] ADDR_STATUS = 12'h378;
  localparam logic [11:0] ADDR_LATCH = 12'h37C;
  localparam logic [11:0] ADDR_EN_FALL = 12'h380;
  localparam logic [11:0] ADDR_EN_RISE = 12'h384;
  localparam logic [11:0] ADDR_TMR_LO = 12'h388;
  localparam logic [11:0] ADDR_TMR_HI = 12'h38C;
  // ==========================================================================
  // Control register fields.
  localparam int CB_PULLUP = 0;
  localparam int CB_VBUS_DRV = 1;
  localparam int CB_DISCHRG = 5;
  localparam int CB_CHRG = 6;
  localparam int CB_SRP_REQ = 8;
  localparam int CB_HNP_EN = 9;
  localparam int CB_BUS_REQ = 11;
  localparam int CB_SUSPEND = 12;
  localparam int CB_DIS_OPT = 13;
  localparam int CB_HOST_DONE = 14;
  // Status, latch, timer and peripheral interrupt fields.
  localparam int SB_ID = 0;
  localparam int SB_SESS_VLD = 1;
  localparam int SB_PLUS_LINE_PULSE_DETECT = 2;
  localparam int SB_BUS_IDLE = 3;
  localparam int LB_TMR = 4;
  localparam int SB_HOST = 5;
  localparam int SB_SESS_END = 7;
  localparam int SB_SE0_IDLE = 8;
  localparam logic [15:0] EDGE_MASK = 16'h000F;
  localparam int TMR_RUN = 31;
  localparam int IB_SUSP = 0;
  localparam int IB_SUSP_EN = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // ==========================================================================
  // Timing: all intervals are counted in ticks of the 0.01 ms time base.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int DP_PULSE_US = 7500;
  localparam int CHRG_US = 15000;
  localparam int DISCHRG_US = 30000;
  localparam int SRP_MAX_US = 100000;
  localparam int B_IDLE_US = 5000;
  localparam int A_IDLE_US = 3000;
  localparam int SETTLE_US = 30;
  localparam int BUS_RESET_US = 10000;
  localparam int ASE0_US = 4000;
  localparam int DP_TICKS = DP_PULSE_US * 1000 / TICK_NS;
  localparam int CHRG_TICKS = CHRG_US * 1000 / TICK_NS;
  localparam int DISCHRG_TICKS = DISCHRG_US * 1000 / TICK_NS;
  localparam int SRP_MAX_TICKS = SRP_MAX_US * 1000 / TICK_NS;
  localparam int B_IDLE_TICKS = B_IDLE_US * 1000 / TICK_NS;
  localparam int A_IDLE_TICKS = A_IDLE_US * 1000 / TICK_NS;
  localparam int SETTLE_TICKS = SETTLE_US * 1000 / TICK_NS;
  localparam int RESET_TICKS = BUS_RESET_US * 1000 / TICK_NS;
  localparam int ASE0_TICKS = ASE0_US * 1000 / TICK_NS;
  // ==========================================================================
  // Types.
  typedef struct packed {
    logic send;
    logic vld;
    logic dm;
    logic dp;
    logic role;
  } pins_t;
  typedef enum logic [3:0] {
    S_IDLE, S_B_SRP_DP, S_B_SRP_CHRG, S_B_SRP_DIS, S_B_PERIPH, S_B_WAIT_ACON,
    S_B_HOST, S_A_WAIT_VRISE, S_A_WAIT_BCON, S_A_HOST, S_A_SUSPEND, S_A_PERIPH
  } fsm_t;
  typedef struct packed {
    fsm_t fsm;
    pins_t s1;
    pins_t s2;
    pins_t s3;
    pins_t f;
    logic [1:0] line_prev;
    logic [15:0] tick_cnt;
    logic [15:0] tmr;
    logic [11:0] idle_ticks;
    logic [15:0] st_prev;
    logic [15:0] ctrl;
    logic [15:0] latch;
    logic [15:0] en_rise;
    logic [15:0] en_fall;
    logic [31:0] timer;
    logic [15:0] irq_periph;
    logic host;
    logic se0_drv;
    logic [31:0] prdata;
  } state_t;
endpackage

/* File: otg_role_ctl.sv */
// OTG port role control: role pin, session request and host hand-off sequencing.
`timescale 1ns/10ps
// Summary of operation
// - Role pin low A-device, high B-device.
// - Session lasts while bus power driven.
// - B-device with valid session enables pull-up.
// - A-device powers bus, hosts after pull-up.
// - Only A-device may drive bus power.
// - Request needs session end and SE0 idle.
// - Pull-up pulse held 5 to 10 ms.
// - Then charge pulse held 10 to 20 ms.
// - Optional discharge for about 30 ms.
// - Whole session request within 100 ms.
// - Pulse on plus line; A detects both.
// - Power pulse detect uses both edge enables.
// - Plus line pulse detect uses rise enable.
// - A suspends after enabling hand-off; B releases.
// - B drops pull-up after 5 ms idle.
// - A raises pull-up within 3 ms of SE0.
// - B waits 30 us, sees J, hosts.
// - New host B resets bus within 1 ms.
// - B host finishes, may restore pull-up.
// - A peripheral drops pull-up after 3 ms idle.
// - A waits 30 us, sees J, resets bus.
// - Bus idle toggles peripheral suspend bit.
// - Control registers have set and clear halves, except the peripheral interrupt register, written directly.
// - Timer with 0.01 ms base flags expiry.
module otg_role_ctl
  import otg_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic role_select_pin,
  input wire logic dp_line,
  input wire logic dm_line,
  input wire logic vbus_sess_vld,
  input wire logic vbus_sess_end,
  output logic plus_line_pullup_ctl,
  output logic bus_power_charge_ctl,
  output logic bus_power_discharge_ctl,
  output logic vbus_drive_ctl,
  output logic bus_reset_se0,
  output logic host_role
);
  // ==========================================================================
  // Declarations.
  localparam state_t ST_RESET = '0;
  state_t q;
  state_t next_st;
  pins_t pins;
  fsm_t dest;
  logic go, tick, line_chg, j_st, se0_st, a_idle, b_idle, wr, mapped;
  logic [15:0] status, rise, fall, setv, lat;
  logic [31:0] rdata;

  // Pins gathered into one carrier before synchronising.
  assign pins = '{send: vbus_sess_end, vld: vbus_sess_vld, dm: dm_line, dp: dp_line,
                  role: role_select_pin};

  // Registers answer at once; an unmapped address is flagged in the access phase.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Read data mux, also telling whether the address is mapped.
  always_comb begin
    mapped = 1'b1;
    rdata = '0;
    case (paddr)
      ADDR_CTRL: rdata = {16'h0000, q.ctrl};
      ADDR_STATUS: rdata = {16'h0000, status};
      ADDR_LATCH: rdata = {16'h0000, q.latch};
      ADDR_EN_FALL: rdata = {16'h0000, q.en_fall};
      ADDR_EN_RISE: rdata = {16'h0000, q.en_rise};
      ADDR_TMR_LO: rdata = {16'h0000, q.timer[15:0]};
      ADDR_TMR_HI: rdata = {16'h0000, q.timer[31:16]};
      ADDR_IRQ_PERIPH: rdata = {16'h0000, q.irq_periph};
      default: mapped = 1'b0;
    endcase
  end

  // Next state of the whole block.
  always_comb begin
    next_st = q;
    go = 1'b0;
    dest = q.fsm;
    // A pin change is taken once the second and third stages agree.
    next_st.s1 = pins;
    next_st.s2 = q.s1;
    next_st.s3 = q.s2;
    next_st.f = (q.s3 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));
    // Time base tick every 0.01 ms.
    tick = (q.tick_cnt >= 16'(TICK_CYC - 1));
    next_st.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
    // Any change of the line pair restarts the idle count.
    next_st.line_prev = {q.f.dm, q.f.dp};
    line_chg = ({q.f.dm, q.f.dp} != q.line_prev);
    if (line_chg) begin
      next_st.idle_ticks = '0;
    end else if (tick && q.idle_ticks != 12'hFFF) begin
      next_st.idle_ticks = q.idle_ticks + 12'h001;
    end
    a_idle = q.idle_ticks > 12'(A_IDLE_TICKS);
    b_idle = q.idle_ticks > 12'(B_IDLE_TICKS);
    j_st = q.f.dp & ~q.f.dm;
    se0_st = ~q.f.dp & ~q.f.dm;
    // Status word and its edges.
    status = '0;
    status[SB_ID] = q.f.role;
    status[SB_SESS_VLD] = q.f.vld;
    status[SB_PLUS_LINE_PULSE_DETECT] = j_st & ~q.f.role & (q.fsm == S_IDLE);
    status[SB_BUS_IDLE] = a_idle;
    status[SB_HOST] = q.host;
    status[SB_SESS_END] = q.f.send;
    status[SB_SE0_IDLE] = se0_st;
    next_st.st_prev = status;
    rise = status & ~q.st_prev;
    fall = ~status & q.st_prev;
    // Power pulses need both edge enables, plus line pulses only the rise one.
    setv = ((rise & q.en_rise) | (fall & q.en_fall)) & EDGE_MASK;
    // Programmable timer counts down in ticks and flags expiry.
    if (tick && q.timer[TMR_RUN]) begin
      if (q.timer[23:0] == 24'h000000) begin
        next_st.timer[TMR_RUN] = 1'b0;
        setv[LB_TMR] = 1'b1;
      end else begin
        next_st.timer[23:0] = q.timer[23:0] - 24'h000001;
      end
    end
    // Per-state interval counter, in ticks.
    if (tick && q.tmr != 16'hFFFF) begin
      next_st.tmr = q.tmr + 16'h0001;
    end
    // Role and protocol sequencer.
    unique case (q.fsm)
      S_IDLE: begin
        next_st.host = 1'b0;
        next_st.se0_drv = 1'b0;
        if (!q.f.role) begin
          // A-device: own request or a detected pulse starts a session.
          // A pulse-started session raises the bus request too, else the session-end check drops it at once.
          if (q.ctrl[CB_BUS_REQ] || q.latch[SB_SESS_VLD] || q.latch[SB_PLUS_LINE_PULSE_DETECT]) begin
            next_st.ctrl[CB_BUS_REQ] = 1'b1;
            next_st.ctrl[CB_VBUS_DRV] = 1'b1;
            dest = S_A_WAIT_VRISE;
            go = 1'b1;
          end
        end else if (q.f.vld) begin
          dest = S_B_PERIPH;
          go = 1'b1;
        end else if (q.ctrl[CB_SRP_REQ]) begin
          next_st.ctrl[CB_SRP_REQ] = 1'b0;
          // A request without a quiet, ended session is dropped.
          if (q.f.send && se0_st) begin
            next_st.ctrl[CB_PULLUP] = 1'b1;
            dest = S_B_SRP_DP;
            go = 1'b1;
          end
        end
      end
      S_B_SRP_DP: begin
        if (q.tmr >= 16'(DP_TICKS)) begin
          next_st.ctrl[CB_PULLUP] = 1'b0;
          next_st.ctrl[CB_CHRG] = 1'b1;
          dest = S_B_SRP_CHRG;
          go = 1'b1;
        end
      end
      S_B_SRP_CHRG: begin
        // Both pulses fit well inside the overall request limit.
        if (q.tmr >= 16'(CHRG_TICKS)) begin
          next_st.ctrl[CB_CHRG] = 1'b0;
          next_st.ctrl[CB_DISCHRG] = q.ctrl[CB_DIS_OPT];
          dest = q.ctrl[CB_DIS_OPT] ? S_B_SRP_DIS : S_IDLE;
          go = 1'b1;
        end
      end
      S_B_SRP_DIS: begin
        if (q.tmr >= 16'(DISCHRG_TICKS)) begin
          next_st.ctrl[CB_DISCHRG] = 1'b0;
          dest = S_IDLE;
          go = 1'b1;
        end
      end
      S_B_PERIPH: begin
        next_st.ctrl[CB_PULLUP] = 1'b1;
        if (!q.f.vld) begin
          next_st.ctrl[CB_PULLUP] = 1'b0;
          dest = S_IDLE;
          go = 1'b1;
        end else if (q.ctrl[CB_HNP_EN] && b_idle) begin
          next_st.ctrl[CB_PULLUP] = 1'b0;
          dest = S_B_WAIT_ACON;
          go = 1'b1;
        end
      end
      S_B_WAIT_ACON: begin
        // Lines are ignored until the old pull-up charge has gone.
        if (q.tmr >= 16'(SETTLE_TICKS) && j_st) begin
          next_st.host = 1'b1;
          next_st.se0_drv = 1'b1;
          dest = S_B_HOST;
          go = 1'b1;
        end else if (q.tmr >= 16'(ASE0_TICKS) || !q.f.vld) begin
          dest = S_IDLE;
          go = 1'b1;
        end
      end
      S_B_HOST: begin
        if (q.tmr >= 16'(RESET_TICKS)) begin
          next_st.se0_drv = 1'b0;
        end
        if (!q.f.vld || q.ctrl[CB_HOST_DONE]) begin
          next_st.ctrl[CB_HOST_DONE] = 1'b0;
          next_st.ctrl[CB_HNP_EN] = 1'b0;
          next_st.host = 1'b0;
          next_st.se0_drv = 1'b0;
          dest = q.f.vld ? S_B_PERIPH : S_IDLE;
          go = 1'b1;
        end
      end
      S_A_WAIT_VRISE: begin
        if (q.f.vld) begin
          dest = S_A_WAIT_BCON;
          go = 1'b1;
        end
      end
      S_A_WAIT_BCON: begin
        // J must hold for the settle time before the connect counts.
        if (!j_st) begin
          next_st.tmr = '0;
        end else if (q.tmr >= 16'(SETTLE_TICKS)) begin
          next_st.host = 1'b1;
          next_st.se0_drv = 1'b1;
          dest = S_A_HOST;
          go = 1'b1;
        end
      end
      S_A_HOST: begin
        if (q.tmr >= 16'(RESET_TICKS)) begin
          next_st.se0_drv = 1'b0;
        end
        if (q.ctrl[CB_SUSPEND] && q.ctrl[CB_HNP_EN] && !q.se0_drv) begin
          next_st.ctrl[CB_SUSPEND] = 1'b0;
          next_st.host = 1'b0;
          dest = S_A_SUSPEND;
          go = 1'b1;
        end
      end
      S_A_SUSPEND: begin
        if (se0_st) begin
          next_st.ctrl[CB_PULLUP] = 1'b1;
          dest = S_A_PERIPH;
          go = 1'b1;
        end
      end
      S_A_PERIPH: begin
        if (a_idle) begin
          next_st.ctrl[CB_PULLUP] = 1'b0;
          next_st.ctrl[CB_HNP_EN] = 1'b0;
          dest = S_A_WAIT_BCON;
          go = 1'b1;
        end
      end
    endcase
    // A-device sessions end when software drops the request or the plug changes.
    if (q.fsm >= S_A_WAIT_VRISE && (q.f.role || !q.ctrl[CB_BUS_REQ])) begin
      next_st.ctrl[CB_VBUS_DRV] = 1'b0;
      next_st.ctrl[CB_PULLUP] = 1'b0;
      next_st.host = 1'b0;
      next_st.se0_drv = 1'b0;
      dest = S_IDLE;
      go = 1'b1;
    end
    if (go) begin
      next_st.fsm = dest;
      next_st.tmr = '0;
    end
    // Bus idle toggles the peripheral suspend bit when enabled.
    if (rise[SB_BUS_IDLE] && q.irq_periph[IB_SUSP_EN]) begin
      next_st.irq_periph[IB_SUSP] = ~q.irq_periph[IB_SUSP];
    end
    // Register writes: low half sets, high half clears; in the peripheral interrupt register only IB_SUSP_EN is written directly.
    wr = psel & penable & pwrite;
    lat = q.latch;
    if (wr) begin
      case (paddr)
        ADDR_CTRL: next_st.ctrl = (next_st.ctrl | pwdata[15:0]) & ~pwdata[31:16];
        ADDR_LATCH: lat = (lat | pwdata[15:0]) & ~pwdata[31:16];
        ADDR_EN_FALL: next_st.en_fall = (q.en_fall | pwdata[15:0]) & ~pwdata[31:16];
        ADDR_EN_RISE: next_st.en_rise = (q.en_rise | pwdata[15:0]) & ~pwdata[31:16];
        ADDR_TMR_LO: next_st.timer[15:0] = (next_st.timer[15:0] | pwdata[15:0]) & ~pwdata[31:16];
        ADDR_TMR_HI: next_st.timer[31:16] = (next_st.timer[31:16] | pwdata[15:0]) & ~pwdata[31:16];
        ADDR_IRQ_PERIPH: next_st.irq_periph[IB_SUSP_EN] = pwdata[IB_SUSP_EN];
        default: ;
      endcase
    end
    // A latch event in the clearing cycle is kept: set wins.
    next_st.latch = lat | setv;
    // Only the A-device may ever power the bus.
    if (q.f.role) begin
      next_st.ctrl[CB_VBUS_DRV] = 1'b0;
    end
    // Read data is captured in the setup phase for the access phase.
    if (psel && !penable) begin
      next_st.prdata = rdata;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= ST_RESET;
    end else begin
      q <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  assign prdata = q.prdata;
  assign plus_line_pullup_ctl = q.ctrl[CB_PULLUP];
  assign bus_power_charge_ctl = q.ctrl[CB_CHRG];
  assign bus_power_discharge_ctl = q.ctrl[CB_DISCHRG];
  assign vbus_drive_ctl = q.ctrl[CB_VBUS_DRV];
  assign bus_reset_se0 = q.se0_drv;
  assign host_role = q.host;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence dp_to_chrg_s;
    (q.fsm == S_B_SRP_DP) ##1 (q.fsm == S_B_SRP_CHRG);
  endsequence
  sequence chrg_end_s;
    (q.fsm == S_B_SRP_CHRG) ##1 (q.fsm != S_B_SRP_CHRG);
  endsequence
  sequence srp_start_s;
    (q.fsm == S_IDLE) ##1 (q.fsm == S_B_SRP_DP);
  endsequence
  sequence acon_to_host_s;
    (q.fsm == S_B_WAIT_ACON) ##1 (q.fsm == S_B_HOST);
  endsequence

  b_no_power_a: assert property (q.f.role |=> !q.ctrl[CB_VBUS_DRV])
    else $error("B-device drives bus power");
  a_start_a: assert property ((q.fsm == S_IDLE && !q.f.role && q.ctrl[CB_BUS_REQ])
    |=> q.fsm == S_A_WAIT_VRISE && q.ctrl[CB_VBUS_DRV]) else $error("A-device did not power bus");
  srp_idle_a: assert property (srp_start_s |-> $past(q.f.send) && !$past(q.f.dp))
    else $error("Session request without idle conditions");
  dp_pulse_a: assert property (dp_to_chrg_s |-> !q.ctrl[CB_PULLUP] && q.ctrl[CB_CHRG]
    && $past(q.tmr) == 16'(DP_TICKS)) else $error("Pull-up pulse length wrong");
  chrg_pulse_a: assert property (chrg_end_s |-> !q.ctrl[CB_CHRG]
    && $past(q.tmr) == 16'(CHRG_TICKS)) else $error("Charge pulse length wrong");
  srp_total_a: assert property ((q.fsm == S_B_SRP_CHRG)
    |-> 32'(q.tmr) + 32'(DP_TICKS) <= 32'(SRP_MAX_TICKS)) else $error("Session request too long");
  b_release_a: assert property ((q.fsm == S_B_PERIPH) ##1 (q.fsm == S_B_WAIT_ACON)
    |-> !q.ctrl[CB_PULLUP] && $past(q.idle_ticks) > 12'(B_IDLE_TICKS)) else $error("Early release");
  b_host_a: assert property (acon_to_host_s |-> q.host && q.se0_drv
    && $past(q.tmr) >= 16'(SETTLE_TICKS)) else $error("Bad host take-over");
  a_pullup_a: assert property ((q.fsm == S_A_SUSPEND && ~q.f.dp && ~q.f.dm && q.f.role == 1'b0
    && q.ctrl[CB_BUS_REQ]) |=> q.ctrl[CB_PULLUP] && q.fsm == S_A_PERIPH) else $error("No pull-up");
  susp_toggle_a: assert property (($rose(q.idle_ticks > 12'(A_IDLE_TICKS)) && q.irq_periph[IB_SUSP_EN])
    |=> ##1 q.irq_periph[IB_SUSP] != $past(q.irq_periph[IB_SUSP], 2)) else $error("Suspend not toggled");
endmodule

/* File: tb_top.sv */
// Self-checking bench for the OTG port role control block.
`timescale 1ns/10ps
module tb_top;
  import otg_pkg::*;
  // A short time base keeps the millisecond intervals cheap to simulate.
  localparam int TC = 2;
  localparam int PU = 0;
  localparam int CH = 1;
  localparam int DI = 2;
  localparam int VB = 3;
  localparam int RS = 4;
  localparam int HO = 5;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic role_select_pin, dp_line, dm_line, vbus_sess_vld, vbus_sess_end, far_pullup, far_vbus;
  logic plus_line_pullup_ctl, bus_power_charge_ctl, bus_power_discharge_ctl;
  logic vbus_drive_ctl, bus_reset_se0, host_role;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] outs;
  int fail_count, cmp_count, n, m;
  assign outs = {host_role, bus_reset_se0, vbus_drive_ctl, bus_power_discharge_ctl,
                 bus_power_charge_ctl, plus_line_pullup_ctl};
  otg_role_ctl #(.TICK_CYC(TC)) u_otg_role_ctl (.mclk(mclk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .role_select_pin(role_select_pin), .dp_line(dp_line),
    .dm_line(dm_line), .vbus_sess_vld(vbus_sess_vld), .vbus_sess_end(vbus_sess_end),
    .plus_line_pullup_ctl(plus_line_pullup_ctl), .bus_power_charge_ctl(bus_power_charge_ctl),
    .bus_power_discharge_ctl(bus_power_discharge_ctl), .vbus_drive_ctl(vbus_drive_ctl),
    .bus_reset_se0(bus_reset_se0), .host_role(host_role));
  otg_far_end u_otg_far_end (.pullup_near(plus_line_pullup_ctl), .reset_near(bus_reset_se0),
    .vbus_near(vbus_drive_ctl), .far_pullup(far_pullup), .far_vbus(far_vbus),
    .dp_line(dp_line), .dm_line(dm_line), .vbus_sess_vld(vbus_sess_vld),
    .vbus_sess_end(vbus_sess_end));
  // ==========================================================================
  // Clock.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ==========================================================================
  // Helpers.
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask
  task rng(input int lo, input int hi, input string what);
    chk({31'h0, (n >= lo && n <= hi)}, 32'h1, what);
  endtask
  // One APB transfer; the request stands until pready is seen at a rising edge.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Bounded wait for one output; the cycle count is left in n.
  task waitv(input int s, input logic v, input int lim);
    n = 0;
    while (outs[s] !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task do_reset(input logic role);
    resetn <= 1'b0;
    role_select_pin <= role;
    far_pullup <= 1'b0;
    far_vbus <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    chk({26'h0, outs}, 32'h0, "outputs after reset");
    repeat (8) @(posedge mclk);
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========================================================================
  // Watchdog: the tests need roughly 20000 cycles, so 50000 means a hang.
  initial begin
    #5000000;
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up;
  end
  // ==========================================================================
  // Tests.
  initial begin
    fail_count = 0;
    cmp_count = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    role_select_pin = 1'b1;
    far_pullup = 1'b0;
    far_vbus = 1'b0;
    @(posedge mclk);
    do_reset(1'b1);
    // Register halves, status, unmapped place and timer.
    apb(1'b1, ADDR_EN_RISE, 32'h0000_0006);
    apb(1'b1, ADDR_EN_RISE, 32'h0002_0002);
    apb(1'b0, ADDR_EN_RISE, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h0000_0004, "set and clear halves");
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk({29'h0, rd[SB_SE0_IDLE], rd[SB_SESS_END], rd[SB_ID]}, 32'h7, "idle status");
    apb(1'b0, 12'h390, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    apb(1'b1, ADDR_TMR_LO, 32'h0000_0005);
    apb(1'b1, ADDR_TMR_HI, 32'h0000_8000);
    apb(1'b0, ADDR_LATCH, 32'h0000_0000);
    chk({31'h0, rd[LB_TMR]}, 32'h0, "timer early");
    repeat (8 * TC) @(posedge mclk);
    apb(1'b0, ADDR_LATCH, 32'h0000_0000);
    chk({31'h0, rd[LB_TMR]}, 32'h1, "timer expiry");
    // A B-device never drives bus power; a request outside session end is refused.
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    far_vbus <= 1'b1;
    waitv(PU, 1'b1, 20);
    chk({30'h0, outs[VB], outs[PU]}, 32'h1, "B session pull-up");
    apb(1'b1, ADDR_CTRL, 32'h0000_0100);
    repeat (10) @(posedge mclk);
    chk({31'h0, outs[CH]}, 32'h0, "request refused");
    far_vbus <= 1'b0;
    repeat (20) @(posedge mclk);
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk({29'h0, rd[CB_SRP_REQ], outs[CH], outs[PU]}, 32'h0, "stale request dropped");
    // Session request with discharge.
    apb(1'b1, ADDR_CTRL, 32'h0000_2100);
    waitv(PU, 1'b1, 20);
    waitv(PU, 1'b0, 1100 * TC);
    m = n;
    rng(500 * TC, 1000 * TC, "dp pulse width");
    chk({31'h0, outs[CH]}, 32'h1, "charge follows");
    waitv(CH, 1'b0, 2100 * TC);
    rng(1000 * TC, 2000 * TC, "charge width");
    n = n + m;
    rng(0, 10000 * TC, "request total");
    chk({31'h0, outs[DI]}, 32'h1, "discharge follows");
    waitv(DI, 1'b0, 3600 * TC);
    rng(2500 * TC, 3500 * TC, "discharge width");
    // B-device takes the host role by hand-off.
    far_vbus <= 1'b1;
    waitv(PU, 1'b1, 20);
    apb(1'b1, ADDR_IRQ_PERIPH, 32'h0000_0100);
    apb(1'b1, ADDR_CTRL, 32'h0000_0200);
    waitv(PU, 1'b0, 700 * TC);
    rng(500 * TC - 10, 600 * TC, "B idle release");
    apb(1'b0, ADDR_IRQ_PERIPH, 32'h0000_0000);
    chk(rd, 32'h0000_0101, "suspend bit toggled");
    repeat (50 * TC) @(posedge mclk);
    far_pullup <= 1'b1;
    waitv(HO, 1'b1, 200 * TC);
    rng(3 * TC, 100 * TC, "B host after J");
    chk({31'h0, outs[RS]}, 32'h1, "B bus reset");
    apb(1'b1, ADDR_CTRL, 32'h0000_4000);
    waitv(PU, 1'b1, 20);
    chk({30'h0, outs[HO], outs[PU]}, 32'h1, "B host done");
    // A-device session and hand-off both ways.
    do_reset(1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk({31'h0, rd[SB_ID]}, 32'h0, "role A");
    apb(1'b1, ADDR_CTRL, 32'h0000_0800);
    waitv(VB, 1'b1, 20);
    chk({31'h0, outs[VB]}, 32'h1, "A powers bus");
    far_pullup <= 1'b1;
    waitv(HO, 1'b1, 100 * TC);
    chk({30'h0, outs[RS], outs[HO]}, 32'h3, "A host");
    waitv(RS, 1'b0, 1100 * TC);
    apb(1'b1, ADDR_CTRL, 32'h0000_1200);
    far_pullup <= 1'b0;
    waitv(PU, 1'b1, 400 * TC);
    rng(0, 300 * TC, "A pull-up after SE0");
    chk({31'h0, outs[HO]}, 32'h0, "A peripheral");
    waitv(PU, 1'b0, 500 * TC);
    rng(300 * TC, 400 * TC, "A idle release");
    far_pullup <= 1'b1;
    waitv(HO, 1'b1, 100 * TC);
    rng(3 * TC, 100 * TC, "A host again");
    chk({31'h0, outs[RS]}, 32'h1, "A bus reset");
    // A-device answers a DP pulse and a bus-power pulse.
    for (int i = 0; i < 2; i++) begin
      do_reset(1'b0);
      apb(1'b1, ADDR_EN_RISE, (i == 0) ? 32'h0000_0004 : 32'h0000_0002);
      apb(1'b1, ADDR_EN_FALL, (i == 0) ? 32'h0000_0000 : 32'h0000_0002);
      far_pullup <= (i == 0);
      far_vbus <= (i == 1);
      repeat (600 * TC) @(posedge mclk);
      far_pullup <= 1'b0;
      far_vbus <= 1'b0;
      waitv(VB, 1'b1, 50 * TC);
      chk({31'h0, outs[VB]}, 32'h1, "request detected");
      repeat (3) @(posedge mclk);
      chk({31'h0, outs[VB]}, 32'h1, "session held");
    end
    wrap_up;
  end
endmodule
